// >>> design/two_wire_slave.sv
// Two-wire serial EEPROM slave: framing, addressing, ack and page buffer.
`timescale 1ns/10ps

// Operation
// - SDA falling with SCL high is Start; new command, framing reset.
// - SDA rising with SCL high is Stop; current operation ends.
// - SDA changes only while SCL low, except Start and Stop.
// - Page buffer keeps the latest thirty-two write bytes, oldest overwritten.
// - Addressed receiver acknowledges every received byte.
// - No acknowledge at all while programming is in progress; here prog_busy only blocks the control-byte ack.
// - Acknowledge holds SDA low across the whole ninth clock high.
// - Master withholds read ack at end; device releases SDA.
// - First byte after Start is the control byte.
// - Control byte: type code, chip select 2..0, read/write bit.
// - Respond only when chip select bits match the pins.
// - On full match acknowledge, then choose read or write.
// - Read/write bit one reads, zero writes.
// - Two address bytes, high first; only thirteen bits kept.
// - Pointer never carries into another device's chip select.
// - Write-protect high blocks array writes; reads unaffected.
// - Page write increments only the five low pointer bits.
// - Write-protect sampled at the Stop of each write.
// - Read pointer increments per byte, wrapping top to zero.
// - Pointer holds last address plus one for current reads.
module two_wire_slave #(
  // Arbitrary device-type code value.
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_clk,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe_n,
  input  wire logic        write_protect,
  input  wire logic        chip_sel_pin_2,
  input  wire logic        chip_sel_pin_1,
  input  wire logic        chip_sel_pin_0,
  input  wire logic        prog_busy,
  input  wire logic [7:0]  rd_data,
  output wire logic [12:0] mem_addr,
  output wire logic        commit,
  output wire logic [7:0]  commit_page,
  output wire logic [31:0] commit_mask,
  input  wire logic [4:0]  buf_rd_idx,
  output wire logic [7:0]  buf_rd_data
);

  // ==========================================================
  // Link domain: data bit taken on the bus clock edge
  logic link_bit_q;
  logic bit_s1_q;
  logic bit_s2_q;

  always_ff @(posedge scl_clk)
    link_bit_q <= sda_in;

  // The bit is stable for a whole SCL period, and the core reads it only
  // after the filtered rising edge, by which time both stages hold it.
  always_ff @(posedge clk)
  begin
    bit_s1_q <= link_bit_q;
    bit_s2_q <= bit_s1_q;
  end

  // ==========================================================
  // Pin filter
  line_if lines ();

  line_filter u_filter (
    .clk      (clk),
    .rst      (rst),
    .pins_raw ({chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0,
                write_protect, sda_in, scl_clk}),
    .lines    (lines)
  );

  // ==========================================================
  // State
  eeprom_pkg::state_type state_q;
  eeprom_pkg::state_type state_d;
  logic [3:0]  cnt_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic [12:0] ptr_q;
  logic [4:0]  hi_q;
  logic        oe_n_q;
  logic        ack_q;
  logic [31:0] mask_q;
  logic        commit_q;
  logic [7:0]  page_q;
  logic [31:0] cmask_q;
  logic [7:0]  bufo_q;
  logic [7:0]  page_buf [eeprom_pkg::PAGE_BYTES];

  // ==========================================================
  // Decode
  wire start = lines.start_evt;
  wire stop = lines.stop_evt;
  wire rise = lines.scl_rise;
  wire fall = lines.scl_fall;
  wire in_ctrl = state_q == eeprom_pkg::S_CTRL;
  wire in_hi = state_q == eeprom_pkg::S_ADDR_HI;
  wire in_lo = state_q == eeprom_pkg::S_ADDR_LO;
  wire in_wr = state_q == eeprom_pkg::S_WDATA;
  wire in_rd = state_q == eeprom_pkg::S_RDATA;
  wire at_ack_fall = fall && cnt_q == eeprom_pkg::CNT_ACK;
  wire at_ack_rise = rise && cnt_q == eeprom_pkg::CNT_ACK;
  wire at_ack_end = fall && cnt_q == eeprom_pkg::CNT_ACK_DONE;
  wire bit_rise = rise && cnt_q < eeprom_pkg::CNT_ACK_DONE;
  wire tx_fall = fall && in_rd && cnt_q >= eeprom_pkg::CNT_FIRST
                 && cnt_q <= eeprom_pkg::CNT_LAST_TX;
  wire [3:0] code_rx = rx_q[eeprom_pkg::CODE_MSB:eeprom_pkg::CODE_LSB];
  wire [2:0] cs_rx = rx_q[eeprom_pkg::CS_MSB:eeprom_pkg::CS_LSB];
  wire is_read = rx_q[eeprom_pkg::RW_POS] == eeprom_pkg::RW_READ;
  wire cs_ok = cs_rx == lines.cs_lvl;
  wire ctrl_ok = code_rx == TYPE_CODE && cs_ok && !prog_busy;
  wire ack_now = (in_ctrl && ctrl_ok) || in_hi || in_lo || in_wr;
  wire master_nack = at_ack_rise && in_rd && bit_s2_q;
  wire load_rd = at_ack_end && in_rd;
  wire store_wr = at_ack_fall && in_wr;
  wire [4:0] slot = ptr_q[eeprom_pkg::PAGE_BITS-1:0];
  wire [12:5] page_sel = ptr_q[eeprom_pkg::ADDR_BITS-1:eeprom_pkg::PAGE_BITS];
  wire do_commit = stop && in_wr && |mask_q && !lines.wp_lvl;

  // ==========================================================
  // Command sequencer
  always_comb
  begin
    state_d = state_q;
    if (at_ack_fall)
    begin
      unique case (state_q)
        eeprom_pkg::S_CTRL:
          if (!ctrl_ok)
            state_d = eeprom_pkg::S_IGNORE;
          else if (is_read)
            state_d = eeprom_pkg::S_RDATA;
          else
            state_d = eeprom_pkg::S_ADDR_HI;
        eeprom_pkg::S_ADDR_HI: state_d = eeprom_pkg::S_ADDR_LO;
        eeprom_pkg::S_ADDR_LO: state_d = eeprom_pkg::S_WDATA;
        eeprom_pkg::S_IDLE,
        eeprom_pkg::S_WDATA,
        eeprom_pkg::S_RDATA,
        eeprom_pkg::S_IGNORE: state_d = state_q;
      endcase
    end
    if (master_nack)
      state_d = eeprom_pkg::S_IGNORE;
  end

  always_ff @(posedge clk)
  begin
    if (rst || stop)
      state_q <= eeprom_pkg::S_IDLE;
    else if (start)
      state_q <= eeprom_pkg::S_CTRL;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // Bit framing and receive shift
  always_ff @(posedge clk)
  begin
    if (rst || start || at_ack_end)
      cnt_q <= eeprom_pkg::CNT_ZERO;
    else if (bit_rise)
      cnt_q <= cnt_q + eeprom_pkg::CNT_FIRST;
    if (rst)
      rx_q <= 8'h00;
    else if (bit_rise && cnt_q < eeprom_pkg::CNT_ACK)
      rx_q <= {rx_q[6:0], bit_s2_q};
  end

  // ==========================================================
  // SDA drive: only ever updated on a falling SCL or at Start/Stop
  always_ff @(posedge clk)
  begin
    if (rst || start || stop)
    begin
      oe_n_q <= 1'b1;
      ack_q  <= 1'b0;
    end
    else if (at_ack_fall)
    begin
      oe_n_q <= !ack_now;
      ack_q  <= ack_now;
    end
    else if (at_ack_end)
    begin
      oe_n_q <= load_rd ? rd_data[7] : 1'b1;
      ack_q  <= 1'b0;
    end
    else if (tx_fall)
      oe_n_q <= tx_q[6];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_q <= 8'h00;
    else if (load_rd)
      tx_q <= rd_data;
    else if (tx_fall)
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // ==========================================================
  // Address pointer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_q <= 13'h0000;
      hi_q  <= 5'h00;
    end
    else if (at_ack_fall && in_hi)
      hi_q <= rx_q[eeprom_pkg::HI_KEEP_BITS-1:0];
    else if (at_ack_fall && in_lo)
      ptr_q <= {hi_q, rx_q};
    else if (store_wr)
      ptr_q[eeprom_pkg::PAGE_BITS-1:0] <= slot + 5'h01;
    else if (load_rd)
      ptr_q <= ptr_q + 13'h0001;
  end

  assign mem_addr = ptr_q;

  // ==========================================================
  // Page buffer and commit
  // keep last 32
  always_ff @(posedge clk)
    if (store_wr)
      page_buf[slot] <= rx_q;

  always_ff @(posedge clk)
  begin
    if (rst || start)
      mask_q <= 32'h00000000;
    else if (store_wr)
      mask_q[slot] <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    commit_q <= !rst && do_commit;
    if (rst)
    begin
      page_q  <= 8'h00;
      cmask_q <= 32'h00000000;
    end
    else if (do_commit)
    begin
      page_q  <= page_sel;
      cmask_q <= mask_q;
    end
  end

  always_ff @(posedge clk)
    bufo_q <= rst ? 8'h00 : page_buf[buf_rd_idx];

  // Open-drain pin: the device only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign commit = commit_q;
  assign commit_page = page_q;
  assign commit_mask = cmask_q;
  assign buf_rd_data = bufo_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_start_frame;
    start |=> cnt_q == eeprom_pkg::CNT_ZERO && in_ctrl;
  endproperty
  a_start_frame: assert property (p_start_frame)
    else $error("Start did not reset framing");

  property p_stop_idle;
    stop |=> state_q == eeprom_pkg::S_IDLE && oe_n_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop did not end the operation");

  property p_sda_low_only;
    $changed(oe_n_q) && !$past(start) && !$past(stop)
      |-> !$past(lines.scl_lvl);
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("SDA drive changed while SCL high");

  property p_busy_silent;
    at_ack_fall && in_ctrl && prog_busy
      |=> oe_n_q ##1 (oe_n_q && !ack_q) [*3];
  endproperty
  a_busy_silent: assert property (p_busy_silent)
    else $error("Acknowledge driven while busy");

  property p_ack_hold;
    ack_q && lines.scl_lvl |-> !oe_n_q && cnt_q >= eeprom_pkg::CNT_ACK;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Acknowledge not held low");

  property p_nack_release;
    master_nack |=> state_q == eeprom_pkg::S_IGNORE ##1 oe_n_q;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("SDA not released after master nack");

  property p_cs_mismatch;
    at_ack_fall && in_ctrl && !cs_ok
      |=> oe_n_q && state_q == eeprom_pkg::S_IGNORE;
  endproperty
  a_cs_mismatch: assert property (p_cs_mismatch)
    else $error("Mismatched chip select answered");

  property p_match_ack;
    at_ack_fall && in_ctrl && ctrl_ok |=> !oe_n_q && ack_q;
  endproperty
  a_match_ack: assert property (p_match_ack)
    else $error("Matched control byte not acknowledged");

  property p_addr_load;
    at_ack_fall && in_lo |=> ptr_q == {$past(hi_q), $past(rx_q)};
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("Word address not loaded");

  property p_wp_commit;
    commit_q |-> !$past(lines.wp_lvl) && $past(stop);
  endproperty
  a_wp_commit: assert property (p_wp_commit)
    else $error("Commit despite write protect");

  property p_page_wrap;
    store_wr |=> ptr_q[12:5] == $past(ptr_q[12:5])
      && ptr_q[4:0] == $past(slot) + 5'h01;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("Page pointer did not wrap in page");

  property p_read_inc;
    load_rd |=> ptr_q == $past(ptr_q) + 13'h0001 && tx_q == $past(rd_data);
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("Read pointer did not advance");

  c_commit: cover property (commit_q);
  c_read: cover property (load_rd);
  c_reject: cover property (at_ack_fall && in_ctrl && !ctrl_ok);
  c_wrap: cover property (store_wr && slot == 5'h1F);

endmodule

// >>> design/eeprom_pkg.sv
// Shared constants and types for the two-wire EEPROM slave front end.
package eeprom_pkg;

  // ==========================================================
  // Array and page geometry
  localparam int ADDR_BITS = 13;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_SEL_BITS = 8;
  localparam int HI_KEEP_BITS = 5;

  // ==========================================================
  // Control byte layout, most significant bit first
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int CS_MSB = 3;
  localparam int CS_LSB = 1;
  localparam int RW_POS = 0;
  localparam logic RW_READ = 1'b1;

  // ==========================================================
  // Bit framing counts within one nine-clock byte slot
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_LAST_TX = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_ACK_DONE = 4'h9;

  // ==========================================================
  // Pin filter lanes and their idle levels
  localparam int PIN_COUNT = 6;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_CS0 = 3;
  localparam int PIN_CS2 = 5;
  localparam logic [5:0] PIN_IDLE = 6'h3F;

  // ==========================================================
  // Command sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_CTRL,
    S_ADDR_HI,
    S_ADDR_LO,
    S_WDATA,
    S_RDATA,
    S_IGNORE
  } state_type;

endpackage

// >>> design/line_if.sv
// Filtered bus levels and bus events passed from the pin filter to the core.
`timescale 1ns/10ps
interface line_if;
  logic       scl_lvl;
  logic       sda_lvl;
  logic       wp_lvl;
  logic [2:0] cs_lvl;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_evt;
  logic       stop_evt;

  modport filt (
    output scl_lvl,
    output sda_lvl,
    output wp_lvl,
    output cs_lvl,
    output scl_rise,
    output scl_fall,
    output start_evt,
    output stop_evt
  );

  modport core (
    input scl_lvl,
    input sda_lvl,
    input wp_lvl,
    input cs_lvl,
    input scl_rise,
    input scl_fall,
    input start_evt,
    input stop_evt
  );
endinterface

// >>> design/line_filter.sv
// Pin synchroniser, spike filter and Start/Stop/edge detector.
`timescale 1ns/10ps
module line_filter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] pins_raw,
  line_if.filt            lines
);

  // ==========================================================
  // Three-stage synchronisers with agreement filter
  logic [eeprom_pkg::PIN_COUNT-1:0] lvl;
  logic [eeprom_pkg::PIN_COUNT-1:0] prv;

  genvar i;
  generate
    for (i = 0; i < eeprom_pkg::PIN_COUNT; i++)
    begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic prv_q;
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1_q  <= eeprom_pkg::PIN_IDLE[i];
          s2_q  <= eeprom_pkg::PIN_IDLE[i];
          s3_q  <= eeprom_pkg::PIN_IDLE[i];
          lvl_q <= eeprom_pkg::PIN_IDLE[i];
          prv_q <= eeprom_pkg::PIN_IDLE[i];
        end
        else
        begin
          s1_q  <= pins_raw[i];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          // A level is taken only once two stages agree.
          if (s2_q == s3_q)
            lvl_q <= s3_q;
          prv_q <= lvl_q;
        end
      end
      assign lvl[i] = lvl_q;
      assign prv[i] = prv_q;
    end
  endgenerate

  // ==========================================================
  // Bus events
  wire scl_now = lvl[eeprom_pkg::PIN_SCL];
  wire scl_was = prv[eeprom_pkg::PIN_SCL];
  wire sda_now = lvl[eeprom_pkg::PIN_SDA];
  wire sda_was = prv[eeprom_pkg::PIN_SDA];
  wire scl_held = scl_now && scl_was;

  assign lines.scl_lvl = scl_now;
  assign lines.sda_lvl = sda_now;
  assign lines.wp_lvl = lvl[eeprom_pkg::PIN_WP];
  assign lines.cs_lvl = lvl[eeprom_pkg::PIN_CS2:eeprom_pkg::PIN_CS0];
  assign lines.scl_rise = scl_now && !scl_was;
  assign lines.scl_fall = !scl_now && scl_was;
  assign lines.start_evt = scl_held && sda_was && !sda_now;
  assign lines.stop_evt = scl_held && !sda_was && sda_now;

endmodule

// >>> verification/bus_master.sv
// Behavioural two-wire bus master that makes SCL and drives SDA.
`timescale 1ns/10ps
module bus_master (
  output logic      scl,
  output logic      pull,
  input  wire logic sda,
  output int        glitches
);
  // ==========================================================
  // Idle bus
  // both lines released
  initial
  begin
    scl      = 1'b1;
    pull     = 1'b0;
    glitches = 0;
  end

  // ==========================================================
  // Conditions and bits
  // start or restart
  task automatic start_cond();
    #10 pull = 1'b0;
    #20 scl = 1'b1;
    #40 pull = 1'b1;
    #40 scl = 1'b0;
  endtask

  task automatic put_bit(input logic b, output logic got);
    logic s0;
    #20 pull = ~b;
    #20 scl = 1'b1;
    s0 = sda;
    #20 got = sda;
    // SDA seen moving mid-high is counted for the bench to judge.
    #20 if (sda !== s0) glitches++;
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], b);
    put_bit(1'b1, b);
    ack = ~b;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, b);
      d[i] = b;
    end
    put_bit(~ack, b);
  endtask

  task automatic stop_cond();
    #20 pull = 1'b1;
    #20 scl = 1'b1;
    #40 pull = 1'b0;
    #80;
  endtask
endmodule

// >>> verification/two_wire_slave_test.sv
// Self-checking bench for the two-wire EEPROM slave front end.
`timescale 1ns/10ps
module two_wire_slave_test;
  // Arbitrary device-type code value.
  localparam logic [3:0] TC = 4'h6;

  typedef struct {
    logic [3:0] code;
    logic [2:0] c;
    logic       rw;
    logic       bsy;
    logic       ack;
  } row_type;

  // ==========================================================
  // Signals
  logic        clk;
  logic        rst;
  logic        scl;
  logic        pull;
  logic        sda;
  logic        wp;
  logic [2:0]  cs;
  logic        busy;
  logic [4:0]  idx;
  logic [7:0]  rd_data;
  logic        sda_out;
  logic        sda_oe_n;
  logic [12:0] mem_addr;
  logic        commit;
  logic [7:0]  commit_page;
  logic [31:0] commit_mask;
  logic [7:0]  buf_rd_data;
  logic        ack;
  logic        ok;
  logic [7:0]  d;
  int          kk;
  int          glitches;
  int          commits;
  int          n_errors;
  int          tests_run;
  row_type     rows [7];

  assign sda = !(pull || (sda_oe_n === 1'b0 && sda_out === 1'b0));
  // Array model answers at once, as the read path expects.
  assign rd_data = mem_addr[7:0] ^ 8'h5A;

  always #2 clk = ~clk;

  always @(posedge clk)
    if (rst)
      commits <= 0;
    else if (commit === 1'b1)
      commits <= commits + 1;

  bus_master m (
    .scl      (scl),
    .pull     (pull),
    .sda      (sda),
    .glitches (glitches)
  );

  two_wire_slave #(
    .TYPE_CODE (TC)
  ) uut (
    .clk            (clk),
    .rst            (rst),
    .scl_clk        (scl),
    .sda_in         (sda),
    .sda_out        (sda_out),
    .sda_oe_n       (sda_oe_n),
    .write_protect  (wp),
    .chip_sel_pin_2 (cs[2]),
    .chip_sel_pin_1 (cs[1]),
    .chip_sel_pin_0 (cs[0]),
    .prog_busy      (busy),
    .rd_data        (rd_data),
    .mem_addr       (mem_addr),
    .commit         (commit),
    .commit_page    (commit_page),
    .commit_mask    (commit_mask),
    .buf_rd_idx     (idx),
    .buf_rd_data    (buf_rd_data)
  );

  // ==========================================================
  // Checks and closing
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr_hdr(input logic [7:0] hi, input logic [7:0] lo);
    m.start_cond();
    m.send_byte({TC, cs, 1'b0}, ack);
    ok = ack;
    m.send_byte(hi, ack);
    ok &= ack;
    m.send_byte(lo, ack);
    ok &= ack;
  endtask

  // A hang ends the run here as a mismatch.
  initial
  begin
    #400000;
    n_errors++;
    $display("BAD %0t run limit reached", $time);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    wp = 1'b0;
    cs = 3'h5;
    busy = 1'b0;
    idx = 5'h00;
    n_errors = 0;
    tests_run = 0;
    rows = '{'{TC, 3'h5, 1'b1, 1'b0, 1'b1}, '{TC, 3'h5, 1'b0, 1'b0, 1'b1},
             '{4'h9, 3'h5, 1'b0, 1'b0, 1'b0}, '{TC, 3'h4, 1'b0, 1'b0, 1'b0},
             '{TC, 3'h7, 1'b0, 1'b0, 1'b0}, '{TC, 3'h1, 1'b0, 1'b0, 1'b0},
             '{TC, 3'h5, 1'b0, 1'b1, 1'b0}};
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk_vec(sda_oe_n, 1'b1);
    chk_vec({commit, mem_addr}, 14'h0000);
    chk_vec({commit_page, buf_rd_data, sda_out}, 17'h00000);
    chk_vec(commit_mask, 32'h00000000);
    @(posedge clk) rst <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test reset done");

    foreach (rows[i])
    begin
      @(posedge clk) busy <= rows[i].bsy;
      m.start_cond();
      m.send_byte({rows[i].code, rows[i].c, rows[i].rw}, ack);
      chk_vec(ack, rows[i].ack);
      if (ack && rows[i].rw)
      begin
        m.recv_byte(1'b0, d);
        chk_vec(d, 8'h5A);
      end
      m.stop_cond();
      @(posedge clk) busy <= 1'b0;
    end
    @(posedge clk) cs <= 3'h0;
    repeat (8) @(posedge clk);
    m.start_cond();
    m.send_byte({TC, 3'h0, 1'b0}, ack);
    m.stop_cond();
    @(posedge clk) cs <= 3'h5;
    repeat (8) @(posedge clk);
    chk_vec(ack, 1'b1);
    chk_vec(commits, 32'h0);
    $display("test control table done");

    // Thirty-four bytes from slot 30 wrap twice into the page start.
    wr_hdr(8'hE3, 8'h1E);
    for (int k = 0; k < 34; k++)
    begin
      m.send_byte(8'(k) + 8'h40, ack);
      ok &= ack;
    end
    m.stop_cond();
    chk_vec(ok, 1'b1);
    chk_vec(commits, 32'h1);
    chk_vec(commit_page, 8'h18);
    chk_vec(commit_mask, 32'hFFFFFFFF);
    chk_vec(mem_addr, 13'h0300);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk) idx <= 5'(i);
      @(posedge clk);
      @(negedge clk);
      kk = (i + 2) % 32;
      if (kk < 2)
        kk += 32;
      chk_vec(buf_rd_data, 8'(kk) + 8'h40);
    end
    $display("test page write done");

    @(posedge clk) wp <= 1'b1;
    wr_hdr(8'h00, 8'h10);
    m.send_byte(8'h77, ack);
    m.stop_cond();
    @(posedge clk) wp <= 1'b0;
    repeat (20) @(posedge clk);
    chk_vec({ok, ack}, 2'h3);
    chk_vec(commits, 32'h1);
    $display("test write protect done");

    wr_hdr(8'hFF, 8'hFF);
    m.start_cond();
    m.send_byte({TC, cs, 1'b1}, ack);
    chk_vec({ok, ack}, 2'h3);
    m.recv_byte(1'b1, d);
    chk_vec(d, 8'hFF ^ 8'h5A);
    m.recv_byte(1'b0, d);
    chk_vec(d, 8'h5A);
    m.stop_cond();
    m.start_cond();
    m.send_byte({TC, cs, 1'b1}, ack);
    m.recv_byte(1'b0, d);
    m.stop_cond();
    chk_vec(d, 8'h01 ^ 8'h5A);
    chk_vec(commits, 32'h1);
    chk_vec(glitches, 32'h0);
    $display("test reads done");

    // A reset in mid-run must clear the pointer and the commit copies.
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_vec({commit_page, mem_addr, sda_oe_n}, 22'h000001);
    chk_vec({commit_mask, buf_rd_data}, 40'h0000000000);
    @(posedge clk) rst <= 1'b0;
    repeat (8) @(posedge clk);
    m.start_cond();
    m.send_byte({TC, cs, 1'b1}, ack);
    m.recv_byte(1'b0, d);
    m.stop_cond();
    chk_vec({ack, d}, 9'h15A);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
